// ### shared/tws_consts.vh
// Behaviour
// - only one of spi or two-wire owns pins
// - spi control bit 5 set gives spi pins
// - software master and hardware slave roles supported
// - master drives data-out bit when enable set
// - in master role, data enable bit makes data pin output
// - in master role, clock-out bit appears on clock pin
// - in master role with data enable clear, data pin latched into data-in bit on clock rise
// - control bit 3 selects master or slave
// - control bit 2 holds slave in reset
// - direction bit set while slave transmits
// - byte-done flag set per data byte, not for the address byte, software clears
// - address register seven bits, resets to 55h
// - data write transmits, read returns received byte
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
`define TWS_ADDR_DATA     8'h9a
`define TWS_ADDR_SLAVE    8'h9b
`define TWS_ADDR_CONTROL  8'he8
`define TWS_RST_DATA      8'h00
`define TWS_RST_SLAVE     8'h55
`define TWS_RST_CONTROL   8'h00
`define TWS_BIT_MDO       7
`define TWS_BIT_MDE       6
`define TWS_BIT_MCO       5
`define TWS_BIT_MDI       4
`define TWS_BIT_ROLE      3
`define TWS_BIT_IRST      2
`define TWS_BIT_DIR       1
`define TWS_BIT_DONE      0
`define TWS_BIT_SPI_SEL   5
`endif

// ### verilog/tws_sync.v
`timescale 1ns/1ns
`default_nettype none
// two flop synchroniser for one pin level
module tws_sync
#(
    parameter INIT = 1'b1
)
(
    // clock and reset
    input  wire sys_clk,
    input  wire rst_n,
    // pin in, synchronised out
    input  wire pin_in,
    output reg  pin_sync
);
    reg meta; // first stage, read only by pin_sync

    // second flop alone reads the first
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta     <= INIT;
            pin_sync <= INIT;
        end
        else
        begin
            meta     <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule // tws_sync
`default_nettype wire

// ### verilog/tws_slave_engine.v
`timescale 1ns/1ns
`default_nettype none
`include "tws_consts.vh"
// hardware slave bit engine: start/stop, address match, byte shift, ack
module tws_slave_engine
(
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // control
    input  wire       enable,
    input  wire [6:0] own_addr,
    input  wire [7:0] tx_byte,
    // synchronised bus levels
    input  wire       scl,
    input  wire       sda,
    // status
    output reg        sda_low,
    output reg        transmitting,
    output reg        byte_done,
    output reg  [7:0] rx_byte
);
    localparam ST_IDLE = 3'd0; // wait for start
    localparam ST_ADDR = 3'd1; // shifting address byte
    localparam ST_AACK = 3'd2; // ack of address
    localparam ST_RX   = 3'd3; // receiving data byte
    localparam ST_RACK = 3'd4; // ack of received data
    localparam ST_TX   = 3'd5; // sending data byte
    localparam ST_TACK = 3'd6; // reading master ack

    reg [2:0] state;
    reg [7:0] shift;   // shift register
    reg [3:0] bits;    // bit count within byte
    reg       scl_d;   // delayed clock level
    reg       sda_d;   // delayed data level
    wire      rise  = scl & ~scl_d;
    wire      fall  = ~scl & scl_d;
    wire      start = scl & scl_d & sda_d & ~sda;
    wire      stop  = scl & scl_d & ~sda_d & sda;

    // single state machine; edge detect uses synchronised levels only
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE; shift <= 8'h00; bits <= 4'h0;
            scl_d <= 1'b1; sda_d <= 1'b1; sda_low <= 1'b0;
            transmitting <= 1'b0; byte_done <= 1'b0; rx_byte <= 8'h00;
        end
        else
        begin
            scl_d     <= scl;
            sda_d     <= sda;
            byte_done <= 1'b0;
            if (!enable)
            begin
                // held in reset
                state <= ST_IDLE; sda_low <= 1'b0; transmitting <= 1'b0;
            end
            else if (start)
            begin
                state <= ST_ADDR; bits <= 4'h0; sda_low <= 1'b0;
            end
            else if (stop)
            begin
                state <= ST_IDLE; sda_low <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_ADDR, ST_RX:
                    begin
                        if (rise)
                        begin
                            shift <= {shift[6:0], sda};
                            bits  <= bits + 4'h1;
                        end
                        else if (fall && bits == 4'h8)
                        begin
                            bits <= 4'h0;
                            if (state == ST_RX)
                            begin
                                rx_byte   <= shift;
                                byte_done <= 1'b1;
                                sda_low   <= 1'b1;
                                state     <= ST_RACK;
                            end
                            else if (shift[7:1] == own_addr)
                            begin
                                sda_low      <= 1'b1;
                                transmitting <= shift[0];
                                state        <= ST_AACK;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    end
                    ST_AACK, ST_RACK:
                    begin
                        if (fall)
                        begin
                            if (transmitting)
                            begin
                                shift   <= tx_byte;
                                sda_low <= ~tx_byte[7];
                                bits    <= 4'h1;
                                state   <= ST_TX;
                            end
                            else
                            begin
                                sda_low <= 1'b0;
                                state   <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (fall)
                        begin
                            if (bits == 4'h8)
                            begin
                                sda_low   <= 1'b0;
                                byte_done <= 1'b1;
                                state     <= ST_TACK;
                            end
                            else
                            begin
                                sda_low <= ~shift[6];
                                shift   <= {shift[6:0], 1'b0};
                                bits    <= bits + 4'h1;
                            end
                        end
                    end
                    ST_TACK:
                    begin
                        // nack from master ends the read
                        if (rise)
                            state <= sda ? ST_IDLE : ST_RACK;
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // tws_slave_engine
`default_nettype wire

// ### verilog/tws_two_wire_port.v
`timescale 1ns/1ns
`default_nettype none
`include "tws_consts.vh"
// two-wire port: software master bit-bang and hardware slave
module tws_two_wire_port
(
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // special-function register port
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    // pin ownership from the spi control register
    input  wire       spi_port_select,
    // serial data pin (oe low = driving)
    input  wire       serial_data_pin_in,
    output reg        serial_data_pin_out,
    output reg        serial_data_pin_oe_n,
    // serial clock pin (oe low = driving)
    input  wire       serial_clock_pin_in,
    output reg        serial_clock_pin_out,
    output reg        serial_clock_pin_oe_n
);
    reg  [7:0] twowire_control;       // control bits
    reg  [7:0] twowire_slave_address; // own bus address
    reg  [7:0] twowire_data;          // received byte
    reg  [7:0] tx_hold;               // byte to send
    reg        scl_prev;              // for master sample edge
    wire       scl_s;                 // synchronised clock pin
    wire       sda_s;                 // synchronised data pin
    wire       eng_sda_low;
    wire       eng_tx;
    wire       eng_done;
    wire [7:0] eng_rx;

    // pin ownership: spi has pins when select is set
    wire tw_owns   = ~spi_port_select;
    wire role_mst  = twowire_control[`TWS_BIT_ROLE];
    wire slave_en  = tw_owns & ~role_mst & ~twowire_control[`TWS_BIT_IRST];
    wire wr_ctl    = sfr_wr && sfr_addr == `TWS_ADDR_CONTROL;
    wire scl_rise  = scl_s & ~scl_prev;

    // pin level synchronisers; data pin sampled through two flops
    tws_sync #(.INIT(1'b1)) u_scl_sync
    (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   (serial_clock_pin_in),
        .pin_sync (scl_s)
    );
    tws_sync #(.INIT(1'b1)) u_sda_sync
    (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   (serial_data_pin_in),
        .pin_sync (sda_s)
    );

    // slave engine, kept idle in master role or while held in reset
    tws_slave_engine u_slave
    (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .enable       (slave_en),
        .own_addr     (twowire_slave_address[6:0]),
        .tx_byte      (tx_hold),
        .scl          (scl_s),
        .sda          (sda_s),
        .sda_low      (eng_sda_low),
        .transmitting (eng_tx),
        .byte_done    (eng_done),
        .rx_byte      (eng_rx)
    );

    // register writes and hardware updates
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            twowire_control       <= `TWS_RST_CONTROL;
            twowire_slave_address <= `TWS_RST_SLAVE;
            twowire_data          <= `TWS_RST_DATA;
            tx_hold               <= `TWS_RST_DATA;
            scl_prev              <= 1'b1;
        end
        else
        begin
            scl_prev <= scl_s;
            // software writes whole control byte, done bit too; direction bit only in master role
            if (wr_ctl)
                twowire_control <= sfr_wdata;
            // direction follows the engine in slave role
            if (!role_mst)
                twowire_control[`TWS_BIT_DIR] <= eng_tx;
            // set wins over a clear in the same cycle
            if (eng_done && !role_mst)
                twowire_control[`TWS_BIT_DONE] <= 1'b1;
            // data-in latched on clock rise when not driving
            if (role_mst && !twowire_control[`TWS_BIT_MDE] && scl_rise)
                twowire_control[`TWS_BIT_MDI] <= sda_s;
            // address writable at any time
            if (sfr_wr && sfr_addr == `TWS_ADDR_SLAVE)
                twowire_slave_address <= {1'b0, sfr_wdata[6:0]};
            // write supplies next byte to send
            if (sfr_wr && sfr_addr == `TWS_ADDR_DATA)
                tx_hold <= sfr_wdata;
            // receive path; software reads once per flag
            if (eng_done && !eng_tx)
                twowire_data <= eng_rx;
        end
    end

    // read data and pin drivers, all registered
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfr_rdata             <= 8'h00;
            serial_data_pin_out   <= 1'b1;
            serial_data_pin_oe_n  <= 1'b1;
            serial_clock_pin_out  <= 1'b1;
            serial_clock_pin_oe_n <= 1'b1;
        end
        else
        begin
            // unmapped addresses read zero
            if (sfr_rd)
            begin
                case (sfr_addr)
                    `TWS_ADDR_CONTROL: sfr_rdata <= twowire_control;
                    `TWS_ADDR_SLAVE:   sfr_rdata <= twowire_slave_address;
                    `TWS_ADDR_DATA:    sfr_rdata <= twowire_data;
                    default:           sfr_rdata <= 8'h00;
                endcase
            end
            if (!tw_owns)
            begin
                // spi owns the pins; release both
                serial_data_pin_oe_n  <= 1'b1;
                serial_clock_pin_oe_n <= 1'b1;
            end
            else if (role_mst)
            begin
                // software master drives clock, data when enabled
                serial_clock_pin_out  <= twowire_control[`TWS_BIT_MCO];
                serial_clock_pin_oe_n <= 1'b0;
                serial_data_pin_out   <= twowire_control[`TWS_BIT_MDO];
                serial_data_pin_oe_n  <= ~twowire_control[`TWS_BIT_MDE];
            end
            else
            begin
                // slave: open-drain style low only, clock never driven
                serial_clock_pin_oe_n <= 1'b1;
                serial_data_pin_out   <= 1'b0;
                serial_data_pin_oe_n  <= ~eng_sda_low;
            end
        end
    end
endmodule // tws_two_wire_port
`default_nettype wire

// ### tb/tws_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "tws_consts.vh"
// pin levels checked against the control value last written
module tws_props
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // pins
    input wire logic       spi_port_select,
    input wire logic       serial_data_pin_in,
    input wire logic       serial_data_pin_out,
    input wire logic       serial_data_pin_oe_n,
    input wire logic       serial_clock_pin_in,
    input wire logic       serial_clock_pin_out,
    input wire logic       serial_clock_pin_oe_n
);
    logic [7:0] ctl;   // control shadow
    logic [1:0] age;   // cycles since control write, saturates
    logic [1:0] spi_q; // spi select history
    logic [6:0] adr;   // address shadow
    logic       rd_d;  // control read taken last edge
    logic       flag1; // previous control read showed byte done
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // shadows; age lets the registered pins settle before judging
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl   <= 8'h00;
            age   <= 2'h0;
            spi_q <= 2'h0;
            adr   <= 7'h55;
            rd_d  <= 1'b0;
            flag1 <= 1'b0;
        end
        else
        begin
            spi_q <= {spi_q[0], spi_port_select};
            rd_d  <= sfr_rd && sfr_addr == `TWS_ADDR_CONTROL;
            if (sfr_wr && sfr_addr == `TWS_ADDR_SLAVE)
                adr <= sfr_wdata[6:0];
            if (sfr_wr && sfr_addr == `TWS_ADDR_CONTROL)
            begin
                ctl   <= sfr_wdata;
                age   <= 2'h0;
                flag1 <= 1'b0;
            end
            else
            begin
                // saturate so a long idle stays judged
                if (age != 2'h3)
                    age <= age + 2'h1;
                if (rd_d)
                    flag1 <= sfr_rdata[0];
            end
        end
    end
    wire logic mst = ctl[3] && age == 2'h3 && spi_q == 2'h0 && !spi_port_select;
    wire logic slv = !ctl[3] && age == 2'h3;
    spi_release_a: assert property (spi_port_select && spi_q == 2'h3 |->
        serial_data_pin_oe_n && serial_clock_pin_oe_n) else $error("pins driven under spi");
    data_enable_a: assert property (mst |-> serial_data_pin_oe_n == !ctl[6])
        else $error("data enable wrong");
    data_value_a: assert property (mst && ctl[6] |-> serial_data_pin_out == ctl[7])
        else $error("data value wrong");
    clock_value_a: assert property (mst |->
        !serial_clock_pin_oe_n && serial_clock_pin_out == ctl[5]) else $error("clock wrong");
    slave_clock_a: assert property (slv |-> serial_clock_pin_oe_n)
        else $error("slave drives clock");
    slave_reset_a: assert property (slv && ctl[2] |-> serial_data_pin_oe_n)
        else $error("slave in reset drives data");
    addr_value_a: assert property (sfr_rd && sfr_addr == `TWS_ADDR_SLAVE |=>
        sfr_rdata == {1'b0, $past(adr)}) else $error("address read wrong");
    flag_hold_a: assert property (rd_d && flag1 |-> sfr_rdata[0])
        else $error("byte done lost");
    cover property (mst && ctl[6]);
    cover property (spi_q == 2'h3);
    cover property (rd_d && flag1);
endmodule // tws_props
bind tws_two_wire_port tws_props u_props
(
    .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .spi_port_select(spi_port_select), .serial_data_pin_in(serial_data_pin_in),
    .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe_n(serial_data_pin_oe_n),
    .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n)
);
`default_nettype wire

// ### tb/tws_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
// external master: pulls only, clock stands high between frames
module tws_bus_master
(
    // resolved data level
    input  wire logic sda_bus,
    // pulls, high = line held low
    output var  logic sda_low,
    output var  logic scl_low
);
    // both lines released at time zero
    initial
    begin
        sda_low = 1'b0;
        scl_low = 1'b0;
    end
    // data falls while the clock is high
    task start;
        sda_low = 1'b1;
        #80;
        scl_low = 1'b1;
        #80;
    endtask
    // one 160 ns period, data set while low, sampled at the end of high
    task bit_io(input logic b, output logic r);
        sda_low = !b;
        #40;
        scl_low = 1'b0;
        #80;
        r = sda_bus;
        scl_low = 1'b1;
        #40;
    endtask
    // msb first, then the acknowledge slot
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(ack_in, ack);
    endtask
    // data rises while the clock is high
    task stop;
        sda_low = 1'b1;
        #40;
        scl_low = 1'b0;
        #80;
        sda_low = 1'b0;
        #80;
    endtask
    // static level for master-mode sampling
    task hold_sda(input logic lvl);
        sda_low = !lvl;
    endtask
endmodule // tws_bus_master
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tws_consts.vh"
// register tasks on the falling edge; reads judged from a queue of notes
module tb;
    logic        sys_clk;
    logic        rst_n;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic        spi_port_select;
    wire  [7:0]  sfr_rdata;
    wire         sda_out;
    wire         sda_oe_n;
    wire         scl_out;
    wire         scl_oe_n;
    wire         sda_low;
    wire         scl_low;
    // pull-ups win wherever nobody drives
    wire         sda_bus = !sda_low && (sda_oe_n || sda_out);
    wire         scl_bus = !scl_low && (scl_oe_n || scl_out);
    logic [15:0] exp_q[$]; // mask and expected read value
    logic [15:0] note;
    logic        rd_d;
    logic [7:0]  rnd;
    logic [7:0]  got;
    logic        ack;
    int          num_errors;
    int          n_compared;
    tws_two_wire_port uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .spi_port_select(spi_port_select), .serial_data_pin_in(sda_bus),
        .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n),
        .serial_clock_pin_in(scl_bus), .serial_clock_pin_out(scl_out),
        .serial_clock_pin_oe_n(scl_oe_n)
    );
    tws_bus_master bm (.sda_bus(sda_bus), .sda_low(sda_low), .scl_low(scl_low));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask
    // the note is queued as the strobe goes up
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        exp_q.push_back({m, e});
        @(negedge sys_clk);
        sfr_rd = 1'b0;
    endtask
    // long enough for sync flops and edge detection
    task settle;
        repeat (6) @(negedge sys_clk);
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // read data is registered on the taking edge, judged at the next
    always @(posedge sys_clk)
    begin
        rd_d <= sfr_rd;
        if (rd_d === 1'b1)
        begin
            note = exp_q.pop_front();
            check("sfr_rdata", sfr_rdata & note[15:8], note[7:0] & note[15:8]);
        end
    end
    // hang guard
    initial
    begin
        for (int w = 0; w < 60000; w++)
            @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end
    initial
    begin
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        spi_port_select = 1'b0;
        num_errors = 0;
        n_compared = 0;
        rnd = 8'h63;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        // power-on values, unmapped read, address width
        rd(`TWS_ADDR_DATA, 8'h00, 8'hff);
        rd(`TWS_ADDR_SLAVE, 8'h55, 8'hff);
        rd(`TWS_ADDR_CONTROL, 8'h00, 8'hff);
        rd(8'h10, 8'h00, 8'hff);
        wr(`TWS_ADDR_SLAVE, 8'hff);
        rd(`TWS_ADDR_SLAVE, 8'h7f, 8'hff);
        wr(`TWS_ADDR_SLAVE, 8'h55);
        // software master with random data, enable and clock bits
        repeat (6)
        begin
            rnd = lfsr(rnd);
            wr(`TWS_ADDR_CONTROL, {rnd[7:5], 5'h08});
            settle();
            check("data_oe_n", {7'h00, sda_oe_n}, {7'h00, !rnd[6]});
            if (rnd[6])
                check("data_out", {7'h00, sda_out}, {7'h00, rnd[7]});
            check("clock", {6'h00, scl_oe_n, scl_out}, {7'h00, rnd[5]});
        end
        // data-in taken on a rising clock with the data line released
        repeat (2)
        begin
            rnd = lfsr(rnd);
            wr(`TWS_ADDR_CONTROL, 8'h08);
            bm.hold_sda(rnd[0]);
            settle();
            wr(`TWS_ADDR_CONTROL, 8'h28);
            settle();
            rd(`TWS_ADDR_CONTROL, {3'h1, rnd[0], 4'h8}, 8'hf8);
        end
        // spi takes the pins
        wr(`TWS_ADDR_CONTROL, 8'h68);
        spi_port_select = 1'b1;
        settle();
        check("spi_owns", {6'h00, sda_oe_n, scl_oe_n}, 8'h03);
        // back to slave while spi still holds the pins, so the master role
        // never pulls data low on the handover and hides the next start
        bm.hold_sda(1'b1);
        wr(`TWS_ADDR_CONTROL, 8'h00);
        spi_port_select = 1'b0;
        settle();
        // slave receive: own address then a random byte
        rnd = lfsr(rnd);
        bm.start();
        bm.xfer(8'haa, 1'b1, got, ack);
        check("addr_ack", {7'h00, ack}, 8'h00);
        bm.xfer(rnd, 1'b1, got, ack);
        check("data_ack", {7'h00, ack}, 8'h00);
        bm.stop();
        rd(`TWS_ADDR_DATA, rnd, 8'hff);
        rd(`TWS_ADDR_CONTROL, 8'h01, 8'h03);
        rd(`TWS_ADDR_CONTROL, 8'h01, 8'h01);
        wr(`TWS_ADDR_CONTROL, 8'h00);
        // a foreign address gets no answer and no flag
        bm.start();
        bm.xfer(8'h54, 1'b1, got, ack);
        check("other_ack", {7'h00, ack}, 8'h01);
        bm.stop();
        rd(`TWS_ADDR_CONTROL, 8'h00, 8'h01);
        // slave transmit, direction seen mid frame
        rnd = lfsr(rnd);
        wr(`TWS_ADDR_DATA, rnd);
        bm.start();
        bm.xfer(8'hab, 1'b1, got, ack);
        rd(`TWS_ADDR_CONTROL, 8'h02, 8'h02);
        bm.xfer(8'hff, 1'b1, got, ack);
        check("tx_byte", got, rnd);
        bm.stop();
        // interface held in reset stays silent
        wr(`TWS_ADDR_CONTROL, 8'h04);
        bm.start();
        bm.xfer(8'haa, 1'b1, got, ack);
        check("reset_ack", {7'h00, ack}, 8'h01);
        bm.stop();
        settle();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
